// file: branch_target_and_implied_operand.sv
// next fetch address, branch destinations and implied accumulator selection
//
// Summary of operation
// - Without a branch the program counter moves on by the byte length of the instruction.
// - Each fetch address is the program counter joined with the current bank selection.
// - A branch loads its computed destination into the program counter and fetching resumes there.
// - A relative branch adds the sign-extended 8-bit displacement to the next instruction start.
// - Relative reach is -128 to +127 bytes from the next instruction start.
// - The relative jump and every conditional branch use relative destination forming.
// - The 16-bit absolute call and jump copy the immediate address into the program counter.
// - The fixed-area call always lands between 0800H and 0FFFH.
// - A table call picks an entry with immediate bits 1 to 5 and loads its stored address.
// - Table entries sit at 0040H to 007FH and may hold any destination.
// - The register jump copies the 16-bit accumulator pair into the program counter.
// - Multiply takes the 8-bit accumulator as multiplicand and writes the pair.
// - Word divide reads the dividend from the pair and returns the quotient there.
// - Both decimal adjusts correct the 8-bit accumulator in place.
// - Both digit rotations use the 8-bit accumulator as the digit holder.
`timescale 1ns/1ps
module branch_target_and_implied_operand (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rst_n,
	// decoded instruction
	input  wire logic                          instr_valid,
	input  wire branch_target_pkg::op_t        instr_op,
	input  wire logic [2:0]                    instr_len,
	input  wire logic                          cond_true,
	input  wire logic [7:0]                    signed_branch_displacement,
	input  wire logic [15:0]                   abs_target,
	input  wire logic [10:0]                   fixed_area_call_target,
	input  wire logic [7:0]                    table_call_imm,
	input  wire logic [15:0]                   accumulator_pair,
	input  wire logic [1:0]                    bank_sel,
	// vector table loading
	input  wire logic                          table_wr_en,
	input  wire logic [15:0]                   table_wr_addr,
	input  wire logic [15:0]                   table_wr_data,
	// program counter and fetch
	output logic      [15:0]                   pc_q,
	output logic      [17:0]                   fetch_addr_q,
	output logic                               ready_q,
	output logic                               branch_q,
	output logic                               call_q,
	output logic      [15:0]                   return_addr_q,
	// implied operands
	output branch_target_pkg::acc_sel_t        implied_src_q,
	output branch_target_pkg::acc_sel_t        implied_dst_q
);
	vec_tbl_if vt ();

	branch_target_pkg::state_t   state_q;
	branch_target_pkg::state_t   state_d;
	branch_target_pkg::acc_sel_t src_d;
	branch_target_pkg::acc_sel_t dst_d;
	logic [15:0]                 pc_d;
	logic [15:0]                 seq_next;
	logic [15:0]                 rel_target;
	logic [15:0]                 disp_ext;
	logic                        branch_d;
	logic                        call_d;
	logic                        accept;
	logic                        tbl_start;
	logic                        wr_in_table;

	vector_table_mem #(
		.ENTRIES (branch_target_pkg::VEC_ENTRIES)
	) u_vec_mem (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.port    (vt.mem)
	);

	// only aligned words inside the table area are stored
	assign wr_in_table = (table_wr_addr >= branch_target_pkg::VEC_TABLE_FIRST) &&
		(table_wr_addr <= branch_target_pkg::VEC_TABLE_LAST) && !table_wr_addr[0];
	assign vt.wr_en    = table_wr_en && wr_in_table;
	assign vt.wr_idx   = table_wr_addr[branch_target_pkg::VEC_IDX_MSB:branch_target_pkg::VEC_IDX_LSB];
	assign vt.wr_data  = table_wr_data;

	// table entry selected by immediate bits 1 to 5
	assign accept     = instr_valid && (state_q == branch_target_pkg::ST_RUN);
	assign vt.rd_en   = tbl_start;
	assign vt.rd_idx  = table_call_imm[branch_target_pkg::VEC_IDX_MSB:branch_target_pkg::VEC_IDX_LSB];

	// sequential address and signed displacement
	assign seq_next   = pc_q + 16'(instr_len);
	assign disp_ext   = {{8{signed_branch_displacement[branch_target_pkg::DISP_SIGN_BIT]}},
		signed_branch_displacement};
	assign rel_target = seq_next + disp_ext;

	// destination selection per instruction class
	always_comb begin
		pc_d      = pc_q;
		state_d   = state_q;
		branch_d  = 1'b0;
		call_d    = 1'b0;
		tbl_start = 1'b0;
		if (state_q == branch_target_pkg::ST_TABLE) begin
			pc_d     = vt.rd_data;
			branch_d = 1'b1;
			state_d  = branch_target_pkg::ST_RUN;
		end else if (accept) begin
			unique case (instr_op)
				branch_target_pkg::OP_REL_JUMP: begin
					pc_d     = rel_target;
					branch_d = 1'b1;
				end
				branch_target_pkg::OP_COND_BRANCH: begin
					pc_d     = cond_true ? rel_target : seq_next;
					branch_d = cond_true;
				end
				branch_target_pkg::OP_CALL_ABS: begin
					pc_d     = abs_target;
					branch_d = 1'b1;
					call_d   = 1'b1;
				end
				branch_target_pkg::OP_JUMP_ABS: begin
					pc_d     = abs_target;
					branch_d = 1'b1;
				end
				branch_target_pkg::OP_FIXED_AREA_CALL: begin
					pc_d     = {branch_target_pkg::FIXED_AREA_UPPER, fixed_area_call_target};
					branch_d = 1'b1;
					call_d   = 1'b1;
				end
				branch_target_pkg::OP_TABLE_CALL: begin
					tbl_start = 1'b1;
					call_d    = 1'b1;
					state_d   = branch_target_pkg::ST_TABLE;
				end
				branch_target_pkg::OP_JUMP_PAIR: begin
					pc_d     = accumulator_pair;
					branch_d = 1'b1;
				end
				branch_target_pkg::OP_SEQUENTIAL,
				branch_target_pkg::OP_UNSIGNED_MULTIPLY,
				branch_target_pkg::OP_UNSIGNED_WORD_DIVIDE,
				branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_ADD,
				branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_SUB,
				branch_target_pkg::OP_DIGIT_ROTATE_RIGHT,
				branch_target_pkg::OP_DIGIT_ROTATE_LEFT: begin
					pc_d = seq_next;
				end
			endcase
		end
	end

	// implied accumulator per operation
	always_comb begin
		src_d = branch_target_pkg::ACC_NONE;
		dst_d = branch_target_pkg::ACC_NONE;
		unique case (instr_op)
			branch_target_pkg::OP_UNSIGNED_MULTIPLY: begin
				src_d = branch_target_pkg::ACC_A;
				dst_d = branch_target_pkg::ACC_PAIR;
			end
			branch_target_pkg::OP_UNSIGNED_WORD_DIVIDE: begin
				src_d = branch_target_pkg::ACC_PAIR;
				dst_d = branch_target_pkg::ACC_PAIR;
			end
			branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_ADD,
			branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_SUB: begin
				src_d = branch_target_pkg::ACC_A;
				dst_d = branch_target_pkg::ACC_A;
			end
			branch_target_pkg::OP_DIGIT_ROTATE_RIGHT,
			branch_target_pkg::OP_DIGIT_ROTATE_LEFT: begin
				src_d = branch_target_pkg::ACC_A;
				dst_d = branch_target_pkg::ACC_A;
			end
			branch_target_pkg::OP_SEQUENTIAL,
			branch_target_pkg::OP_REL_JUMP,
			branch_target_pkg::OP_COND_BRANCH,
			branch_target_pkg::OP_CALL_ABS,
			branch_target_pkg::OP_JUMP_ABS,
			branch_target_pkg::OP_FIXED_AREA_CALL,
			branch_target_pkg::OP_TABLE_CALL,
			branch_target_pkg::OP_JUMP_PAIR: begin
				src_d = branch_target_pkg::ACC_NONE;
				dst_d = branch_target_pkg::ACC_NONE;
			end
		endcase
	end

	// program counter and sequencer state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pc_q    <= branch_target_pkg::RESET_PC;
			state_q <= branch_target_pkg::ST_RUN;
		end else begin
			pc_q    <= pc_d;
			state_q <= state_d;
		end
	end

	// fetch address joins bank selection and the new counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fetch_addr_q <= {branch_target_pkg::RESET_BANK, branch_target_pkg::RESET_PC};
		end else begin
			fetch_addr_q <= {bank_sel, pc_d};
		end
	end

	// handshake, branch and call indications
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ready_q       <= 1'b0;
			branch_q      <= 1'b0;
			call_q        <= 1'b0;
			return_addr_q <= 16'h0000;
		end else begin
			ready_q  <= (state_d == branch_target_pkg::ST_RUN);
			branch_q <= branch_d;
			call_q   <= call_d && accept;
			if (call_d && accept) begin
				return_addr_q <= seq_next; // address after the call
			end
		end
	end

	// implied operand selection, held until the next accepted instruction
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			implied_src_q <= branch_target_pkg::ACC_NONE;
			implied_dst_q <= branch_target_pkg::ACC_NONE;
		end else if (accept) begin
			implied_src_q <= src_d;
			implied_dst_q <= dst_d;
		end
	end
endmodule

// file: branch_target_pkg.sv
// shared constants and types for the branch target and implied operand logic
package branch_target_pkg;
	localparam int          PC_W             = 16;
	localparam int          LEN_W            = 3;
	localparam int          BANK_W           = 2;
	localparam int          DISP_W           = 8;
	localparam int          FIXED_W          = 11;
	localparam int          VEC_IDX_W        = 5;
	localparam int          VEC_ENTRIES      = 32;
	localparam int          VEC_IDX_LSB      = 1;
	localparam int          VEC_IDX_MSB      = 5;
	localparam int          DISP_SIGN_BIT    = 7;
	localparam logic [15:0] RESET_PC         = 16'h0000;
	localparam logic [15:0] VEC_TABLE_FIRST  = 16'h0040;
	localparam logic [15:0] VEC_TABLE_LAST   = 16'h007F;
	localparam logic [4:0]  FIXED_AREA_UPPER = 5'h01;
	localparam logic [1:0]  RESET_BANK       = 2'h0;

	// instruction classes presented by the decoder
	typedef enum logic [3:0] {
		OP_SEQUENTIAL,
		OP_REL_JUMP,
		OP_COND_BRANCH,
		OP_CALL_ABS,
		OP_JUMP_ABS,
		OP_FIXED_AREA_CALL,
		OP_TABLE_CALL,
		OP_JUMP_PAIR,
		OP_UNSIGNED_MULTIPLY,
		OP_UNSIGNED_WORD_DIVIDE,
		OP_DECIMAL_ADJUST_AFTER_ADD,
		OP_DECIMAL_ADJUST_AFTER_SUB,
		OP_DIGIT_ROTATE_RIGHT,
		OP_DIGIT_ROTATE_LEFT
	} op_t;

	// implicitly addressed accumulator
	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_A,
		ACC_PAIR
	} acc_sel_t;

	typedef enum logic {
		ST_RUN,
		ST_TABLE
	} state_t;
endpackage

// file: vec_tbl_if.sv
// link between the branch logic and the vector table memory
`timescale 1ns/1ps
interface vec_tbl_if;
	logic        wr_en;
	logic [4:0]  wr_idx;
	logic [15:0] wr_data;
	logic        rd_en;
	logic [4:0]  rd_idx;
	logic [15:0] rd_data;

	modport mem  (input wr_en, input wr_idx, input wr_data, input rd_en, input rd_idx,
		output rd_data);
	modport user (output wr_en, output wr_idx, output wr_data, output rd_en, output rd_idx,
		input rd_data);
endinterface

// file: vector_table_mem.sv
// vector table storage with a registered read port
`timescale 1ns/1ps
module vector_table_mem #(
	parameter int ENTRIES = branch_target_pkg::VEC_ENTRIES
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// table port
	vec_tbl_if.mem    port
);
	logic [15:0] mem_q [ENTRIES];

	// entry write from the loader
	always_ff @(posedge clk_sys) begin
		if (port.wr_en) begin
			mem_q[port.wr_idx] <= port.wr_data;
		end
	end

	// read data comes out of a register one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			port.rd_data <= 16'h0000;
		end else if (port.rd_en) begin
			port.rd_data <= mem_q[port.rd_idx];
		end
	end
endmodule

// file: branch_target_props.sv
// concurrent checks on the branch target and implied operand ports
`timescale 1ns/1ps
module branch_target_props (
	// clock and reset
	input wire logic                       clk_sys,
	input wire logic                       rst_n,
	// decoded instruction
	input wire logic                       instr_valid,
	input wire branch_target_pkg::op_t     instr_op,
	input wire logic [2:0]                 instr_len,
	input wire logic                       cond_true,
	input wire logic [7:0]                 signed_branch_displacement,
	input wire logic [15:0]                abs_target,
	input wire logic [10:0]                fixed_area_call_target,
	input wire logic [15:0]                accumulator_pair,
	input wire logic [1:0]                 bank_sel,
	// results
	input wire logic [15:0]                pc_q,
	input wire logic [17:0]                fetch_addr_q,
	input wire logic                       ready_q,
	input wire logic                       branch_q,
	input wire logic                       call_q,
	input wire branch_target_pkg::acc_sel_t implied_src_q,
	input wire branch_target_pkg::acc_sel_t implied_dst_q
);
	logic        wait_q;
	wire         acc   = instr_valid && !wait_q;
	wire  [15:0] d_ext = {{8{signed_branch_displacement[7]}}, signed_branch_displacement};
	wire  [3:0]  op    = instr_op;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// tracks the one refused cycle that follows an accepted table call
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= acc && op == branch_target_pkg::OP_TABLE_CALL;
		end
	end
	sequence table_take;
		acc && op == branch_target_pkg::OP_TABLE_CALL;
	endsequence
	sequence table_wait;
		!ready_q && call_q && !branch_q && $stable(pc_q);
	endsequence
	sequence table_land;
		ready_q && branch_q;
	endsequence
	seq_adv_a: assert property (acc && (op == branch_target_pkg::OP_SEQUENTIAL ||
		op == branch_target_pkg::OP_COND_BRANCH && !cond_true)
		|=> pc_q == $past(pc_q) + $past(instr_len) && !branch_q) else $error("sequential advance wrong");
	fetch_addr_a: assert property (rst_n |=> fetch_addr_q == {$past(bank_sel), pc_q})
		else $error("fetch address wrong");
	rel_target_a: assert property (acc && (op == branch_target_pkg::OP_REL_JUMP ||
		op == branch_target_pkg::OP_COND_BRANCH && cond_true) |=> branch_q &&
		pc_q == $past(pc_q) + $past(instr_len) + $past(d_ext)) else $error("relative target wrong");
	abs_target_a: assert property (acc && (op == branch_target_pkg::OP_CALL_ABS ||
		op == branch_target_pkg::OP_JUMP_ABS) |=> branch_q && pc_q == $past(abs_target))
		else $error("absolute target wrong");
	fixed_call_a: assert property (acc && op == branch_target_pkg::OP_FIXED_AREA_CALL
		|=> call_q && pc_q == {5'h01, $past(fixed_area_call_target)}) else $error("fixed call wrong");
	pair_jump_a: assert property (acc && op == branch_target_pkg::OP_JUMP_PAIR
		|=> branch_q && !call_q && pc_q == $past(accumulator_pair)) else $error("pair jump wrong");
	table_call_a: assert property (table_take |=> table_wait ##1 table_land)
		else $error("table call timing wrong");
	mul_operand_a: assert property (acc && op == branch_target_pkg::OP_UNSIGNED_MULTIPLY
		|=> implied_src_q == branch_target_pkg::ACC_A && implied_dst_q == branch_target_pkg::ACC_PAIR)
		else $error("multiply operands wrong");
	div_operand_a: assert property (acc && op == branch_target_pkg::OP_UNSIGNED_WORD_DIVIDE
		|=> implied_src_q == branch_target_pkg::ACC_PAIR && implied_dst_q == implied_src_q)
		else $error("divide operands wrong");
	acc_operand_a: assert property (acc && op >= branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_ADD
		|=> implied_src_q == branch_target_pkg::ACC_A && implied_dst_q == branch_target_pkg::ACC_A)
		else $error("accumulator operands wrong");
endmodule
bind branch_target_and_implied_operand branch_target_props props_inst (.*);

// file: tb.sv
// self-checking bench for the branch target and implied operand logic
`timescale 1ns/1ps
module tb;
	logic                        clk_sys = 1'b0, rst_n = 1'b0, vld = 1'b0, cond = 1'b0, wr_en = 1'b0;
	branch_target_pkg::op_t      op = branch_target_pkg::OP_SEQUENTIAL;
	logic [2:0]                  len = 3'h1;
	logic [7:0]                  disp = 8'h00, imm = 8'h00;
	logic [10:0]                 fix = 11'h000;
	logic [15:0]                 abs_t = 16'h0000, pair = 16'h0000, wa = 16'h0000, wd = 16'h0000;
	logic [15:0]                 pc_q, ret_q, pc_e;
	logic [1:0]                  bank = 2'h0;
	logic [17:0]                 fa_q;
	logic                        rdy_q, br_q, call_q;
	branch_target_pkg::acc_sel_t src_q, dst_q;
	int                          n_errors = 0, n_compared = 0;
	always #4 clk_sys = ~clk_sys;
	branch_target_and_implied_operand branch_target_and_implied_operand_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .instr_valid(vld), .instr_op(op), .instr_len(len), .cond_true(cond),
		.signed_branch_displacement(disp), .abs_target(abs_t), .fixed_area_call_target(fix),
		.table_call_imm(imm), .accumulator_pair(pair), .bank_sel(bank), .table_wr_en(wr_en),
		.table_wr_addr(wa), .table_wr_data(wd), .pc_q(pc_q), .fetch_addr_q(fa_q), .ready_q(rdy_q),
		.branch_q(br_q), .call_q(call_q), .return_addr_q(ret_q), .implied_src_q(src_q),
		.implied_dst_q(dst_q));
	task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// present one instruction for one edge, leaving valid high
	task automatic run(branch_target_pkg::op_t o, logic [2:0] l);
		op = o;
		len = l;
		vld = 1'b1;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic stop;
		vld = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk_pc(logic br);
		check("pc", pc_q, pc_e);
		check("fetch", fa_q, {bank, pc_e});
		check("branch", br_q, br);
	endtask
	task automatic t_seq;
		bank = 2'h2;
		pc_e = 16'h0000;
		run(branch_target_pkg::OP_SEQUENTIAL, 3'h3);
		pc_e = 16'h0003;
		chk_pc(1'b0);
		run(branch_target_pkg::OP_SEQUENTIAL, 3'h7);
		pc_e = 16'h000A;
		chk_pc(1'b0);
		run(branch_target_pkg::OP_COND_BRANCH, 3'h2);
		pc_e = 16'h000C;
		chk_pc(1'b0);
		stop;
		$display("sequential test done");
	endtask
	task automatic t_rel;
		bank = 2'h1; // bank selected before the far jump
		abs_t = 16'h1000;
		run(branch_target_pkg::OP_JUMP_ABS, 3'h3);
		pc_e = 16'h1000;
		chk_pc(1'b1);
		disp = 8'h80;
		run(branch_target_pkg::OP_REL_JUMP, 3'h2);
		pc_e = 16'h0F82;
		chk_pc(1'b1);
		disp = 8'h7F;
		cond = 1'b1;
		run(branch_target_pkg::OP_COND_BRANCH, 3'h3);
		pc_e = 16'h1004;
		chk_pc(1'b1);
		abs_t = 16'hFFF0;
		run(branch_target_pkg::OP_JUMP_ABS, 3'h3);
		run(branch_target_pkg::OP_REL_JUMP, 3'h2);
		pc_e = 16'h0071;
		chk_pc(1'b1);
		stop;
		$display("relative test done");
	endtask
	task automatic t_call;
		abs_t = 16'hFFFF;
		fix = 11'h7FF;
		pair = 16'hA55A;
		run(branch_target_pkg::OP_CALL_ABS, 3'h3);
		check("ret", ret_q, 16'h0074);
		check("call", call_q, 1'b1);
		pc_e = 16'hFFFF;
		chk_pc(1'b1);
		run(branch_target_pkg::OP_FIXED_AREA_CALL, 3'h2);
		pc_e = 16'h0FFF;
		chk_pc(1'b1);
		fix = 11'h000;
		run(branch_target_pkg::OP_FIXED_AREA_CALL, 3'h2);
		pc_e = 16'h0800;
		chk_pc(1'b1);
		run(branch_target_pkg::OP_JUMP_PAIR, 3'h1);
		pc_e = 16'hA55A;
		chk_pc(1'b1);
		check("call", call_q, 1'b0);
		stop;
		$display("call test done");
	endtask
	// table call; a jump offered in the wait cycle must be ignored
	task automatic tcall(logic [7:0] i, logic [15:0] exp);
		imm = i;
		run(branch_target_pkg::OP_TABLE_CALL, 3'h2);
		check("wait ready", rdy_q, 1'b0);
		check("wait call", call_q, 1'b1);
		check("ret", ret_q, pc_e + 16'h0002);
		op = branch_target_pkg::OP_JUMP_ABS;
		abs_t = 16'h1234;
		@(posedge clk_sys);
		#1;
		pc_e = exp;
		chk_pc(1'b1);
		check("land ready", rdy_q, 1'b1);
		stop;
	endtask
	task automatic t_table;
		logic [15:0] adr [6] = '{16'h0040, 16'h0042, 16'h007E, 16'h0043, 16'h0080, 16'h003E};
		logic [15:0] dat [6] = '{16'h1111, 16'h2222, 16'h7EEE, 16'hDEAD, 16'hBEEF, 16'hCAFE};
		wr_en = 1'b1;
		for (int k = 0; k < 6; k++) begin
			wa = adr[k];
			wd = dat[k];
			@(posedge clk_sys);
			#1;
		end
		wr_en = 1'b0;
		tcall(8'h00, 16'h1111);
		tcall(8'h3F, 16'h7EEE);
		tcall(8'h02, 16'h2222);
		$display("table test done");
	endtask
	task automatic t_implied;
		branch_target_pkg::op_t o [7] = '{branch_target_pkg::OP_UNSIGNED_MULTIPLY,
			branch_target_pkg::OP_UNSIGNED_WORD_DIVIDE, branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_ADD,
			branch_target_pkg::OP_DECIMAL_ADJUST_AFTER_SUB, branch_target_pkg::OP_DIGIT_ROTATE_RIGHT,
			branch_target_pkg::OP_DIGIT_ROTATE_LEFT, branch_target_pkg::OP_SEQUENTIAL};
		logic [3:0] e [7] = '{4'h6, 4'hA, 4'h5, 4'h5, 4'h5, 4'h5, 4'h0};
		for (int k = 0; k < 7; k++) begin
			run(o[k], 3'h1);
			check("implied", {src_q, dst_q}, e[k]);
		end
		stop;
		$display("implied test done");
	endtask
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence after four reset cycles
	initial begin
		repeat (4) @(posedge clk_sys);
		#1;
		check("reset pc", pc_q, 16'h0000);
		rst_n = 1'b1;
		t_seq;
		t_rel;
		t_call;
		t_table;
		t_implied;
		wrap_up;
	end
	// watchdog
	initial begin
		#20000;
		n_errors++;
		wrap_up;
	end
endmodule
